// ===== rtl/bio_pkg.sv
// Package with register map, function codes, reset values and timing constants.
`default_nettype none
package bio_pkg;
	// Sizes of the input and output sides.
	localparam int NUM_IN = 4;
	localparam int NUM_OUT = 18;
	localparam int NUM_SEL = 4;
	localparam int FIRST_SEL = 14;
	localparam int NUM_IRQ = 5;
	// Register byte offsets.
	localparam logic [7:0] ADDR_IN_FUNC = 8'h00;
	localparam logic [7:0] ADDR_IN_DELAY = 8'h04;
	localparam logic [7:0] ADDR_OUT_FUNC = 8'h08;
	localparam logic [7:0] ADDR_OUT_DIRECT = 8'h0c;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_OUT_STAT = 8'h14;
	localparam logic [7:0] ADDR_EVT_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	// Input function codes, four bits per input.
	localparam logic [3:0] IN_FN_NONE = 4'h0;
	localparam logic [3:0] IN_FN_IMP_P2 = 4'h1;
	localparam logic [3:0] IN_FN_GEN_P3 = 4'h2;
	localparam logic [3:0] IN_FN_IMP_P3 = 4'h3;
	localparam logic [3:0] IN_FN_WARN = 4'h4;
	localparam logic [3:0] IN_FN_ALARM = 4'h5;
	localparam logic [3:0] IN_FN_WARN_OPEN = 4'h6;
	localparam logic [3:0] IN_FN_ALARM_OPEN = 4'h7;
	localparam logic [3:0] IN_FN_WARN_CLOSED = 4'h8;
	localparam logic [3:0] IN_FN_ALARM_CLOSED = 4'h9;
	localparam logic [3:0] IN_FN_OVERLOAD = 4'ha;
	// Output function codes for the selectable outputs fifteen to eighteen.
	localparam logic [3:0] OUT_FN_UNUSED = 4'h0;
	localparam logic [3:0] OUT_FN_DIRECT = 4'h1;
	localparam logic [3:0] OUT_FN_STEADY_A = 4'h2;
	localparam logic [3:0] OUT_FN_STEADY_B = 4'h3;
	localparam logic [3:0] OUT_FN_WARNING = 4'h4;
	localparam logic [3:0] OUT_FN_ALARM = 4'h5;
	localparam logic [3:0] OUT_FN_BLOCK = 4'h6;
	// Reset values.
	localparam logic [15:0] OUT_FUNC_RST = 16'h3200;
	localparam logic [15:0] IN_FUNC_RST = 16'h0000;
	localparam logic [15:0] IN_DELAY_RST = 16'h0000;
	// Display page codes.
	localparam logic [1:0] PAGE_NORMAL = 2'h0;
	localparam logic [1:0] PAGE_TWO = 2'h2;
	localparam logic [1:0] PAGE_THREE = 2'h3;
	// Interrupt bit positions.
	localparam int IRQ_WARN = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_BLOCK = 2;
	localparam int IRQ_ESTOP = 3;
	localparam int IRQ_PAGE = 4;
	// Delay time base: one millisecond per tick.
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== rtl/bio_top.sv
// Input function and output channel logic with its AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module bio_top import bio_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_IN-1:0] field_in,
	input wire logic relay_common_supply_terminal,
	output logic [NUM_OUT-1:0] dout,
	output logic warning_active,
	output logic alarm_active,
	output logic block_active,
	output logic emergency_stop_alarm,
	output logic page2_text_on,
	output logic page3_text_on,
	output logic [1:0] display_page,
	output logic irq
);
	// Bus state: holding flags for the two write channels.
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] waddr_r; // Captured write address.
	logic [31:0] wdata_r; // Captured write data.
	logic [3:0] wstrb_r; // Captured byte enables.
	logic wr_en; // One write is applied this cycle.
	logic [31:0] wmask; // Byte enables widened to bits.
	// Software registers.
	logic [15:0] in_func_r;
	logic [15:0] in_delay_r;
	logic [15:0] out_func_r;
	logic [NUM_OUT-1:0] out_direct_r;
	logic brk_cmd_r; // Breaker close command.
	logic [NUM_IRQ-1:0] irq_stat_r;
	logic [NUM_IRQ-1:0] irq_mask_r;
	logic [NUM_IRQ-1:0] irq_set; // Events of this cycle.
	// Synchroniser chain; the last bit is the common supply pin.
	logic [NUM_IN:0] s1_r;
	logic [NUM_IN:0] s2_r;
	logic [NUM_IN:0] s3_r;
	logic [NUM_IN:0] filt_r;
	// Time base and per-input delay counters.
	logic [31:0] tick_cnt_r;
	logic tick_r;
	logic [15:0] dcnt_r [NUM_IN];
	logic [NUM_IN-1:0] dly_ok; // Input held long enough.
	// Per-input event sources.
	logic [NUM_IN-1:0] warn_src;
	logic [NUM_IN-1:0] alarm_src;
	logic [NUM_IN-1:0] block_src;
	logic [NUM_IN-1:0] warn_src_r;
	logic [NUM_IN-1:0] alarm_src_r;
	logic [NUM_IN-1:0] block_src_r;
	logic imp2_any;
	logic gen3_any;
	logic imp3_any;
	logic imp2_r; // Previous level, for jump edges.
	logic imp3_r;
	logic [NUM_OUT-1:0] out_nxt;

	// Widens the byte enables to a bit mask, one byte lane per strobe bit.
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wr_en = aw_hold_r && w_hold_r && !s_axi_bvalid;

	// Write channels: address and data are taken in either order and held until both are in.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_r <= s_axi_awaddr;
				aw_hold_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (!aw_hold_r && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_hold_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (!w_hold_r && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_en) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Read-only and unmapped offsets answer with an error.
				s_axi_bresp <= (waddr_r == ADDR_OUT_STAT || waddr_r == ADDR_EVT_STAT ||
					waddr_r > ADDR_IRQ_MASK || waddr_r[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers; output selectors come up unused for fifteen and sixteen.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_func_r <= IN_FUNC_RST;
			in_delay_r <= IN_DELAY_RST;
			out_func_r <= OUT_FUNC_RST;
			out_direct_r <= 18'h00000;
			brk_cmd_r <= 1'b0;
			irq_mask_r <= 5'h00;
		end else if (ce && wr_en) begin
			unique case (waddr_r)
				ADDR_IN_FUNC: in_func_r <= (in_func_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
				ADDR_IN_DELAY: in_delay_r <= (in_delay_r & ~wmask[15:0]) |
					(wdata_r[15:0] & wmask[15:0]);
				ADDR_OUT_FUNC: out_func_r <= (out_func_r & ~wmask[15:0]) |
					(wdata_r[15:0] & wmask[15:0]);
				ADDR_OUT_DIRECT: out_direct_r <= (out_direct_r & ~wmask[17:0]) |
					(wdata_r[17:0] & wmask[17:0]);
				ADDR_CTRL: begin
					if (wstrb_r[0]) begin
						brk_cmd_r <= wdata_r[0];
					end
				end
				ADDR_IRQ_MASK: begin
					if (wstrb_r[0]) begin
						irq_mask_r <= wdata_r[NUM_IRQ-1:0];
					end
				end
				default: begin
					// Other offsets store nothing here.
				end
			endcase
		end
	end

	// Sticky interrupt status; a new event wins over a write-one clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 5'h00;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr_en && waddr_r == ADDR_IRQ_STAT && wstrb_r[0]) begin
				irq_stat_r <= (irq_stat_r & ~wdata_r[NUM_IRQ-1:0]) | irq_set;
			end else begin
				irq_stat_r <= irq_stat_r | irq_set;
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read channel: one read at a time, answered one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					ADDR_IN_FUNC: s_axi_rdata <= {16'h0000, in_func_r};
					ADDR_IN_DELAY: s_axi_rdata <= {16'h0000, in_delay_r};
					ADDR_OUT_FUNC: s_axi_rdata <= {16'h0000, out_func_r};
					ADDR_OUT_DIRECT: s_axi_rdata <= {14'h0000, out_direct_r};
					ADDR_CTRL: s_axi_rdata <= {31'h0000_0000, brk_cmd_r};
					ADDR_OUT_STAT: s_axi_rdata <= {14'h0000, dout};
					ADDR_EVT_STAT: s_axi_rdata <= {11'h000, filt_r[NUM_IN-1:0],
						emergency_stop_alarm, display_page, page3_text_on, page2_text_on,
						block_src_r, alarm_src_r, warn_src_r};
					ADDR_IRQ_STAT: s_axi_rdata <= {27'h0000000, irq_stat_r};
					ADDR_IRQ_MASK: s_axi_rdata <= {27'h0000000, irq_mask_r};
					default: begin
						// Unmapped offsets read zero with an error.
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Field pins pass three flops; a level counts once the last two agree, which drops glitches.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// The chain starts at the idle levels, so no false supply loss follows reset.
			s1_r <= 5'h10;
			s2_r <= 5'h10;
			s3_r <= 5'h10;
			filt_r <= 5'h10;
		end else if (ce) begin
			s1_r <= {relay_common_supply_terminal, field_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (s3_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
		end
	end

	// One-millisecond tick for the input delays.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= (tick_cnt_r == 32'(TICK_LEN - 1));
			tick_cnt_r <= (tick_cnt_r == 32'(TICK_LEN - 1)) ? 32'h0000_0000 : tick_cnt_r + 32'h1;
		end
	end

	// Per-input delay counter and function decode.
	generate
		for (genvar i = 0; i < NUM_IN; i++) begin : g_in
			logic [3:0] fn;
			assign fn = in_func_r[4*i +: 4];
			// Counts held-active milliseconds; resets as soon as the input drops.
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					dcnt_r[i] <= 16'h0000;
				end else if (ce) begin
					if (!filt_r[i]) begin
						dcnt_r[i] <= 16'h0000;
					end else if (tick_r && dcnt_r[i] < in_delay_r) begin
						dcnt_r[i] <= dcnt_r[i] + 16'h1;
					end
				end
			end
			assign dly_ok[i] = filt_r[i] && (dcnt_r[i] >= in_delay_r);
			assign warn_src[i] = dly_ok[i] && ((fn == IN_FN_WARN) ||
				(fn == IN_FN_WARN_OPEN && !brk_cmd_r) ||
				(fn == IN_FN_WARN_CLOSED && brk_cmd_r));
			assign alarm_src[i] = dly_ok[i] && ((fn == IN_FN_ALARM) ||
				(fn == IN_FN_ALARM_OPEN && !brk_cmd_r) ||
				(fn == IN_FN_ALARM_CLOSED && brk_cmd_r));
			assign block_src[i] = dly_ok[i] && (fn == IN_FN_OVERLOAD);
		end
	endgenerate

	// Status page inputs act at once, without the delay.
	always_comb begin
		imp2_any = 1'b0;
		gen3_any = 1'b0;
		imp3_any = 1'b0;
		for (int i = 0; i < NUM_IN; i++) begin
			imp2_any = imp2_any | (filt_r[i] && in_func_r[4*i +: 4] == IN_FN_IMP_P2);
			gen3_any = gen3_any | (filt_r[i] && in_func_r[4*i +: 4] == IN_FN_GEN_P3);
			imp3_any = imp3_any | (filt_r[i] && in_func_r[4*i +: 4] == IN_FN_IMP_P3);
		end
	end

	// Event flags; the emergency stop has no software enable and follows the supply pin whenever ce is high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_src_r <= 4'h0;
			alarm_src_r <= 4'h0;
			block_src_r <= 4'h0;
			warning_active <= 1'b0;
			alarm_active <= 1'b0;
			block_active <= 1'b0;
			emergency_stop_alarm <= 1'b0;
		end else if (ce) begin
			warn_src_r <= warn_src;
			alarm_src_r <= alarm_src;
			block_src_r <= block_src;
			warning_active <= |warn_src;
			alarm_active <= |alarm_src;
			block_active <= |block_src;
			emergency_stop_alarm <= !filt_r[NUM_IN];
		end
	end

	// Display pages; an important input forces its page, page three winning a tie.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			imp2_r <= 1'b0;
			imp3_r <= 1'b0;
			page2_text_on <= 1'b0;
			page3_text_on <= 1'b0;
			display_page <= PAGE_NORMAL;
		end else if (ce) begin
			imp2_r <= imp2_any;
			imp3_r <= imp3_any;
			page2_text_on <= imp2_any;
			page3_text_on <= gen3_any || imp3_any;
			if (imp3_any && !imp3_r) begin
				display_page <= PAGE_THREE;
			end else if (imp2_any && !imp2_r) begin
				display_page <= PAGE_TWO;
			end
		end
	end

	assign irq_set = {(imp2_any && !imp2_r) || (imp3_any && !imp3_r), !filt_r[NUM_IN] &&
		!emergency_stop_alarm, |block_src && !block_active, |alarm_src && !alarm_active,
		|warn_src && !warning_active};

	// Output channels: one to fourteen follow software, fifteen to eighteen follow a selector.
	always_comb begin
		out_nxt = out_direct_r;
		for (int k = 0; k < NUM_SEL; k++) begin
			unique case (out_func_r[4*k +: 4])
				OUT_FN_DIRECT: out_nxt[FIRST_SEL+k] = out_direct_r[FIRST_SEL+k];
				OUT_FN_STEADY_A: out_nxt[FIRST_SEL+k] = !brk_cmd_r;
				OUT_FN_STEADY_B: out_nxt[FIRST_SEL+k] = brk_cmd_r;
				OUT_FN_WARNING: out_nxt[FIRST_SEL+k] = warning_active;
				OUT_FN_ALARM: out_nxt[FIRST_SEL+k] = alarm_active;
				OUT_FN_BLOCK: out_nxt[FIRST_SEL+k] = block_active;
				default: out_nxt[FIRST_SEL+k] = 1'b0;
			endcase
		end
	end

	// Eighteen output flops; the last four relays, the rest static drivers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dout <= 18'h00000;
		end else if (ce) begin
			dout <= out_nxt;
		end
	end

	// Checks; except for chk_out_default, attempts are dropped while reset or clock enable is low.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	chk_estop_supply: assert property (!filt_r[NUM_IN] |=> emergency_stop_alarm)
		else $error("Emergency stop not raised without supply.");
	chk_estop_nomask: assert property ((!relay_common_supply_terminal) [*5] |=> ##[0:1]
		emergency_stop_alarm)
		else $error("Emergency stop missed after supply loss.");
	chk_page2_jump: assert property ($rose(imp2_any) && !$rose(imp3_any) |=>
		display_page == PAGE_TWO && page2_text_on)
		else $error("Page two not forced.");
	chk_page3_text: assert property (gen3_any && !imp3_any && !$rose(imp2_any) |=>
		page3_text_on && $stable(display_page))
		else $error("Generic page three text wrong.");
	chk_page3_jump: assert property ($rose(imp3_any) |=> display_page == PAGE_THREE)
		else $error("Page three not forced.");
	chk_warn_open: assert property (g_in[2].fn == IN_FN_WARN_OPEN && brk_cmd_r |=>
		!warn_src_r[2])
		else $error("Open warning raised with command active.");
	chk_alarm_closed: assert property (g_in[1].fn == IN_FN_ALARM_CLOSED && !brk_cmd_r |=>
		!alarm_src_r[1])
		else $error("Closed alarm raised with command inactive.");
	chk_warn_generic: assert property (dly_ok[0] && g_in[0].fn == IN_FN_WARN |=>
		warn_src_r[0] && warning_active)
		else $error("Generic warning not raised.");
	chk_alarm_generic: assert property (dly_ok[1] && g_in[1].fn == IN_FN_ALARM |=>
		alarm_src_r[1])
		else $error("Generic alarm not raised.");
	chk_overload_blk: assert property (dly_ok[2] && g_in[2].fn == IN_FN_OVERLOAD |=>
		block_src_r[2] && block_active)
		else $error("Overload block not raised.");
	chk_delay_held: assert property ($rose(warn_src_r[0]) |->
		$past(dcnt_r[0]) >= $past(in_delay_r))
		else $error("Warning raised before delay expired.");
	chk_steady_cmd: assert property (out_func_r[15:12] == OUT_FN_STEADY_B |=>
		dout[17] == $past(brk_cmd_r))
		else $error("Output eighteen not following breaker command.");
	chk_out_default: assert property (disable iff (1'b0) !aresetn |=>
		out_func_r == OUT_FUNC_RST && dout == 18'h00000)
		else $error("Output selectors wrong after reset.");
	chk_stat_mirror: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == ADDR_OUT_STAT |=> s_axi_rdata[17:0] == $past(dout))
		else $error("Output status read does not match outputs.");
endmodule // bio_top
`default_nettype wire

// ===== test/bio_field_model.sv
// Field-side model: contacts and the emergency loop that feed the block.
`timescale 1ns/1ps
`default_nettype none
module bio_field_model (
	input wire logic aclk,
	input wire logic [3:0] contact_cmd,
	input wire logic supply_cmd,
	output logic [3:0] field_in,
	output logic relay_common_supply_terminal
);
	// Contacts rest open and the supply loop closed at power-up.
	initial begin
		field_in = 4'h0;
		relay_common_supply_terminal = 1'b1;
	end

	// A contact moves one clock after the bench commands it; real contacts are never faster.
	always @(posedge aclk) begin
		field_in <= contact_cmd;
		relay_common_supply_terminal <= supply_cmd;
	end
endmodule // bio_field_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the breaker input and output block.
`timescale 1ns/1ps
`default_nettype none
module tb import bio_pkg::*;;
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, supply_cmd;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb, contact_cmd, field_in;
	logic awready, wready, bvalid, arready, rvalid, supply_pin, irq;
	logic [1:0] bresp, rresp, display_page, exp_page;
	logic [31:0] rdata;
	logic [17:0] dout;
	logic warning_active, alarm_active, block_active, emergency_stop_alarm;
	logic page2_text_on, page3_text_on;
	logic [4:0] ev_now;
	int fail_count, n_tests;

	// Event outputs gathered in the order that ev_exp returns.
	assign ev_now = {page3_text_on, page2_text_on, block_active, alarm_active, warning_active};

	// A short tick keeps delay tests brief.
	bio_top #(.TICK_LEN(8)) bio_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.field_in(field_in), .relay_common_supply_terminal(supply_pin), .dout(dout),
		.warning_active(warning_active), .alarm_active(alarm_active),
		.block_active(block_active), .emergency_stop_alarm(emergency_stop_alarm),
		.page2_text_on(page2_text_on), .page3_text_on(page3_text_on),
		.display_page(display_page), .irq(irq));

	bio_field_model bio_field_model_i (.aclk(aclk), .contact_cmd(contact_cmd),
		.supply_cmd(supply_cmd), .field_in(field_in), .relay_common_supply_terminal(supply_pin));

	// Free-running 200 MHz clock.
	always #2.5 aclk = ~aclk;

	// Compares one value and counts it; case inequality so unknowns fail.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// One write; address and data offered together, each released when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic done;
		logic [1:0] resp;
		n = 0;
		done = 1'b0;
		resp = 2'bxx;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		chk(resp, er, "write response");
	endtask

	// One read, compared with the expected word and response.
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk(rresp, er, "read response");
				chk(rdata, exp, "read data");
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) chk(1'b0, 1'b1, "read never answered");
	endtask

	// Expected {page3, page2, block, alarm, warning} for one input code and breaker command.
	function automatic logic [4:0] ev_exp(input logic [3:0] c, input logic b);
		logic [4:0] e;
		e = 5'h00;
		case (c)
			IN_FN_IMP_P2: e[3] = 1'b1;
			IN_FN_GEN_P3, IN_FN_IMP_P3: e[4] = 1'b1;
			IN_FN_WARN: e[0] = 1'b1;
			IN_FN_ALARM: e[1] = 1'b1;
			IN_FN_WARN_OPEN: e[0] = !b;
			IN_FN_ALARM_OPEN: e[1] = !b;
			IN_FN_WARN_CLOSED: e[0] = b;
			IN_FN_ALARM_CLOSED: e[1] = b;
			IN_FN_OVERLOAD: e[2] = 1'b1;
			default: e = 5'h00;
		endcase
		return e;
	endfunction

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog sized well above the fewer than a thousand cycles the tests need.
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end

	// Main sequence.
	initial begin
		int idx;
		aclk = 1'b0;
		aresetn = 1'b0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		contact_cmd = 4'h0;
		supply_cmd = 1'b1;
		fail_count = 0;
		n_tests = 0;
		exp_page = PAGE_NORMAL;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		wait_cyc(2);
		// Reset values, an unmapped read and a write to a read-only word.
		axi_rd(ADDR_OUT_FUNC, {16'h0, OUT_FUNC_RST}, RESP_OKAY);
		axi_rd(ADDR_IN_FUNC, 32'h0, RESP_OKAY);
		axi_rd(ADDR_IN_DELAY, 32'h0, RESP_OKAY);
		axi_rd(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
		axi_rd(8'h24, 32'h0, RESP_SLVERR);
		axi_wr(ADDR_OUT_STAT, 32'h1, RESP_SLVERR);
		// Every input code with both breaker commands, spread over all four inputs.
		for (int c = 0; c < 11; c++) begin
			for (int b = 0; b < 2; b++) begin
				idx = c % 4;
				axi_wr(ADDR_IN_FUNC, 32'(c) << (4 * idx), RESP_OKAY);
				axi_wr(ADDR_CTRL, 32'(b), RESP_OKAY);
				contact_cmd <= 4'h1 << idx;
				wait_cyc(12);
				if (c == IN_FN_IMP_P2) exp_page = PAGE_TWO;
				else if (c == IN_FN_IMP_P3) exp_page = PAGE_THREE;
				chk(ev_now, ev_exp(c[3:0], b[0]), "event outputs");
				chk(display_page, exp_page, "display page");
				chk(dout[17:16], {b[0], !b[0]}, "breaker relays");
				contact_cmd <= 4'h0;
				wait_cyc(12);
				chk(ev_now, 5'h00, "events released");
			end
		end
		// Outputs fifteen and sixteen each follow their own selector.
		axi_wr(ADDR_OUT_DIRECT, 32'h3c0a5, RESP_OKAY);
		axi_wr(ADDR_OUT_FUNC, 32'h0010, RESP_OKAY);
		wait_cyc(4);
		chk(dout, 18'h080a5, "out16 direct");
		axi_rd(ADDR_OUT_STAT, 32'h080a5, RESP_OKAY);
		axi_wr(ADDR_OUT_FUNC, 32'h0001, RESP_OKAY);
		wait_cyc(4);
		chk(dout, 18'h040a5, "out15 direct");
		// A delayed warning ignores a short pulse and rises after three ticks.
		axi_wr(ADDR_IN_FUNC, {28'h0, IN_FN_WARN}, RESP_OKAY);
		axi_wr(ADDR_IN_DELAY, 32'h3, RESP_OKAY);
		contact_cmd <= 4'h1;
		wait_cyc(14);
		contact_cmd <= 4'h0;
		wait_cyc(30);
		chk(warning_active, 1'b0, "short pulse");
		contact_cmd <= 4'h1;
		wait_cyc(10);
		chk(warning_active, 1'b0, "delay running");
		wait_cyc(30);
		chk(warning_active, 1'b1, "delay expired");
		contact_cmd <= 4'h0;
		// Emergency stop, its interrupt masked, enabled and cleared.
		axi_wr(ADDR_IRQ_STAT, 32'h1f, RESP_OKAY);
		supply_cmd <= 1'b0;
		wait_cyc(10);
		chk(emergency_stop_alarm, 1'b1, "supply lost");
		chk(irq, 1'b0, "irq masked");
		axi_wr(ADDR_IRQ_MASK, 32'h1 << IRQ_ESTOP, RESP_OKAY);
		wait_cyc(3);
		chk(irq, 1'b1, "irq enabled");
		axi_wr(ADDR_IN_FUNC, 32'h0, RESP_OKAY);
		axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		axi_wr(ADDR_IRQ_STAT, 32'h1 << IRQ_ESTOP, RESP_OKAY);
		wait_cyc(3);
		chk(irq, 1'b0, "irq cleared");
		chk(emergency_stop_alarm, 1'b1, "alarm persists");
		supply_cmd <= 1'b1;
		wait_cyc(10);
		chk(emergency_stop_alarm, 1'b0, "supply back");
		close_out();
	end
endmodule // tb
`default_nettype wire
